// ### rtl/sss_top.sv
// Design decision made here: the AXI4-Lite register port.
module sss_top
  import sss_pkg::*;
#(
  parameter int unsigned P_SELECTION_TIMEOUT_FLAG_MAX_CYC = SELECTION_TIMEOUT_FLAG_MAX_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register bus
  input wire sss_axi_req_s i_axi,
  output sss_axi_rsp_s o_axi,
  // SCSI bus
  input wire sss_bus_in_s i_bus,
  output sss_bus_out_s o_bus_out,
  output sss_bus_out_s o_bus_oe,
  // Transfer counter step
  input wire logic i_byte_done
);

  // ==========================================================================
  // Register bus slave
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  wire aw_take = i_axi.awvalid & o_axi.awready;
  wire w_take = i_axi.wvalid & o_axi.wready;
  wire wr_fire = aw_have & w_have & ~o_axi.bvalid;
  wire rd_fire = i_axi.arvalid & o_axi.arready;
  // Only byte lane 0 carries a register; a write without it is answered but ignored.
  wire wr_en = wr_fire & w_lane0;
  wire wr_seq = wr_en & (aw_addr == ADDR_SEQ);
  wire wr_xc0 = wr_en & (aw_addr == ADDR_XC0);
  wire wr_xc1 = wr_en & (aw_addr == ADDR_XC1);
  wire wr_idsel = wr_en & (aw_addr == ADDR_IDSEL);
  wire wr_st0 = wr_en & (aw_addr == ADDR_ST0);
  wire wr_st1 = wr_en & (aw_addr == ADDR_ST1);
  wire wr_hit = (aw_addr == ADDR_SEQ) | (aw_addr == ADDR_XC0) | (aw_addr == ADDR_XC1) |
                (aw_addr == ADDR_IDSEL) | (aw_addr == ADDR_ST0) | (aw_addr == ADDR_ST1);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_byte <= REG_RST;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have <= 1'b1;
        aw_addr <= i_axi.awaddr;
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (w_take) begin
        w_have <= 1'b1;
        w_byte <= i_axi.wdata[7:0];
        w_lane0 <= i_axi.wstrb[0];
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Control and status registers
  logic [7:0] seq;
  logic [7:0] xc0;
  logic [7:0] xc1;
  logic [7:0] idsel;
  logic [23:0] xfer_cnt;
  logic st_target;
  logic st_done;
  logic st_sel_in;
  logic st_timeout;
  logic st_perr;
  logic atn_q;
  logic req_q;
  logic [TMR_W-1:0] tmr;
  sss_state_e state;
  sss_state_e next_state;

  wire bus_free = ~i_bus.bsy & ~i_bus.sel;
  wire [2:0] own_id = idsel[ID_OWN_LO +: 3];
  wire [2:0] dest_id = idsel[ID_DEST_LO +: 3];
  wire [7:0] own_bit = 8'h01 << own_id;
  wire [7:0] dest_bit = 8'h01 << dest_id;
  wire par_en = xc1[XC1_PAR_EN];
  // Each step of the select code halves the limit from the longest timeout.
  wire [1:0] tsel = xc1[XC1_TSEL_LO +: 2];
  wire [TMR_W-1:0] sel_limit = TMR_W'(P_SELECTION_TIMEOUT_FLAG_MAX_CYC >> tsel);
  wire sel_start = (state == ST_IDLE) & seq[SEQ_SEL_OUT_EN] & bus_free & ~i_bus.rst;
  wire got_bsy = (state == ST_SELECTING) & i_bus.bsy;
  wire timed_out = (state == ST_SELECTING) & ~i_bus.bsy & xc1[XC1_TMR_EN] & (tmr >= sel_limit);
  wire sel_abort = (state == ST_SELECTING) & ~seq[SEQ_SEL_OUT_EN];
  wire sel_end = got_bsy | timed_out;
  // Answering starts from idle only, so an own selection never answers itself.
  wire in_cand = (state == ST_IDLE) & ~sel_start & i_bus.sel & ~i_bus.bsy & ((i_bus.data & own_bit) != 8'h00);
  wire sel_in = in_cand & ~i_bus.io & seq[SEQ_SEL_IN_EN];
  wire resel_in = in_cand & i_bus.io & seq[SEQ_RESEL_IN_EN];
  wire in_phase = i_bus.io & ~(~i_bus.cd & i_bus.msg);
  wire par_bad = ~(^{i_bus.data, i_bus.dp});
  // Parity is judged once per REQ rising edge, so a long REQ counts one error.
  wire perr_evt = par_en & i_bus.req & ~req_q & in_phase & par_bad;
  wire atn_set = (sel_start & ~seq[SEQ_TEMODE] & seq[SEQ_AUTO_SEL]) |
                 (resel_in & seq[SEQ_AUTO_RESEL]) |
                 (perr_evt & seq[SEQ_AUTO_PAR]);
  // Own drivers count as bus activity, or automatic attention would drop while SEL or BSY is still driven just after the state returns to idle.
  wire bus_idle = bus_free & (state == ST_IDLE) & ~o_bus_out.bsy & ~o_bus_out.sel;
  // Set wins over clear so an event in the clearing cycle is kept.
  wire atn_clr = (wr_st1 & w_byte[ST1_CLRATN]) | bus_idle;

  // Software write first, then hardware end-of-sequence, then bus reset.
  logic [7:0] next_seq;
  always_comb begin
    next_seq = wr_seq ? w_byte : seq;
    if (sel_end) begin
      next_seq[SEQ_SEL_OUT_EN] = 1'b0;
    end
    if (i_bus.rst) begin
      next_seq = next_seq & SEQ_BUSRST_KEEP;
    end
  end

  // ==========================================================================
  // Selection sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sel_start) begin
          next_state = ST_SELECTING;
        end else if (sel_in | resel_in) begin
          next_state = ST_ANSWER;
        end
      end
      ST_SELECTING: begin
        if (sel_end | sel_abort | i_bus.rst) begin
          next_state = ST_IDLE;
        end
      end
      ST_ANSWER: begin
        // Busy is held until the selecting device lets SEL go.
        if (~i_bus.sel | i_bus.rst) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      seq <= REG_RST;
      xc0 <= REG_RST;
      xc1 <= REG_RST;
      idsel <= REG_RST;
      state <= ST_IDLE;
      req_q <= 1'b0;
      tmr <= '0;
    end else begin
      seq <= next_seq;
      state <= next_state;
      req_q <= i_bus.req;
      if (wr_xc0) begin
        xc0 <= w_byte & XC0_MASK;
      end
      if (wr_xc1) begin
        xc1 <= w_byte & XC1_MASK;
      end
      if (wr_idsel) begin
        idsel <= w_byte & IDSEL_MASK;
      end
      // The timer only runs while selecting, so a stale count never shortens the next attempt.
      tmr <= (state == ST_SELECTING) ? tmr + 1'b1 : '0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_target <= 1'b0;
      st_done <= 1'b0;
      st_sel_in <= 1'b0;
      st_timeout <= 1'b0;
      st_perr <= 1'b0;
      atn_q <= 1'b0;
      xfer_cnt <= CNT_RST;
    end else begin
      if (sel_in) begin
        st_target <= 1'b1;
      end else if (resel_in) begin
        st_target <= 1'b0;
      end
      st_done <= got_bsy | (st_done & ~(wr_st0 & w_byte[ST0_SEL_DONE]));
      st_sel_in <= sel_in | resel_in | (st_sel_in & ~(wr_st0 & w_byte[ST0_SEL_IN]));
      st_timeout <= timed_out | (st_timeout & ~(wr_st1 & w_byte[ST1_SEL_TIMEOUT]));
      st_perr <= perr_evt | (st_perr & ~(wr_st1 & w_byte[ST1_PERR]));
      atn_q <= atn_set | (atn_q & ~atn_clr);
      // The clear bit holds the counter at zero until software drops it again.
      if (xc0[XC0_CLRCNT]) begin
        xfer_cnt <= CNT_RST;
      end else if (i_byte_done) begin
        xfer_cnt <= xfer_cnt + 24'h000001;
      end
    end
  end

  // ==========================================================================
  // SCSI drivers
  // Pins are open-drain, so value and enable carry the same asserted level.
  sss_bus_out_s next_drv;
  always_comb begin
    next_drv.sel = (state == ST_SELECTING);
    next_drv.io = (state == ST_SELECTING) & seq[SEQ_TEMODE];
    next_drv.data = (state == ST_SELECTING) ? (own_bit | dest_bit) : 8'h00;
    next_drv.bsy = (state == ST_ANSWER);
    next_drv.atn = atn_q;
    next_drv.rst = seq[SEQ_RSTO];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_out <= '0;
      o_bus_oe <= '0;
    end else begin
      o_bus_out <= next_drv;
      o_bus_oe <= next_drv;
    end
  end

  // ==========================================================================
  // Read path and bus answers
  wire [7:0] st0_val = {st_target, st_done, st_sel_in, state == ST_SELECTING, 4'h0};
  wire [7:0] st1_val = {st_timeout, 4'h0, st_perr & par_en, 2'h0};
  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (i_axi.araddr)
      ADDR_SEQ: rd_val = {24'h000000, seq};
      ADDR_XC0: rd_val = {24'h000000, xc0};
      ADDR_XC1: rd_val = {24'h000000, xc1};
      ADDR_IDSEL: rd_val = {24'h000000, idsel};
      ADDR_CNT: rd_val = {8'h00, xfer_cnt};
      ADDR_ST0: rd_val = {24'h000000, st0_val};
      ADDR_ST1: rd_val = {24'h000000, st1_val};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data is captured at the take, so a later register change cannot tear it.
  // Ready drops in the take cycle, so no second request is accepted before the answer.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_axi <= '0;
    end else begin
      o_axi.awready <= ~aw_have & ~aw_take;
      o_axi.wready <= ~w_have & ~w_take;
      if (wr_fire) begin
        o_axi.bvalid <= 1'b1;
        o_axi.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi.bready) begin
        o_axi.bvalid <= 1'b0;
      end
      o_axi.arready <= ~o_axi.rvalid & ~rd_fire;
      if (rd_fire) begin
        o_axi.rvalid <= 1'b1;
        o_axi.rdata <= rd_val;
        o_axi.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_axi.rready) begin
        o_axi.rvalid <= 1'b0;
      end
    end
  end

endmodule : sss_top

// ### include/sss_pkg.sv
package sss_pkg;
  // ==========================================================================
  // Bus widths and answers
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam int IDX_SEQ = 'h340;
  localparam int IDX_XC0 = 'h341;
  localparam int IDX_XC1 = 'h342;
  localparam int IDX_IDSEL = 'h345;
  localparam int IDX_CNT = 'h348;
  localparam int IDX_ST0 = 'h34B;
  localparam int IDX_ST1 = 'h34C;
  localparam logic [ADDR_W-1:0] ADDR_SEQ = ADDR_W'(IDX_SEQ * 4);
  localparam logic [ADDR_W-1:0] ADDR_XC0 = ADDR_W'(IDX_XC0 * 4);
  localparam logic [ADDR_W-1:0] ADDR_XC1 = ADDR_W'(IDX_XC1 * 4);
  localparam logic [ADDR_W-1:0] ADDR_IDSEL = ADDR_W'(IDX_IDSEL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CNT = ADDR_W'(IDX_CNT * 4);
  localparam logic [ADDR_W-1:0] ADDR_ST0 = ADDR_W'(IDX_ST0 * 4);
  localparam logic [ADDR_W-1:0] ADDR_ST1 = ADDR_W'(IDX_ST1 * 4);

  // ==========================================================================
  // Field positions, masks and reset values
  localparam int SEQ_TEMODE = 7;
  localparam int SEQ_SEL_OUT_EN = 6;
  localparam int SEQ_SEL_IN_EN = 5;
  localparam int SEQ_RESEL_IN_EN = 4;
  localparam int SEQ_AUTO_SEL = 3;
  localparam int SEQ_AUTO_RESEL = 2;
  localparam int SEQ_AUTO_PAR = 1;
  localparam int SEQ_RSTO = 0;
  localparam logic [7:0] SEQ_BUSRST_KEEP = 8'h01;
  localparam int XC0_CLRCNT = 4;
  localparam logic [7:0] XC0_MASK = 8'hFA;
  localparam int XC1_PAR_EN = 5;
  localparam int XC1_TSEL_LO = 3;
  localparam int XC1_TMR_EN = 2;
  localparam logic [7:0] XC1_MASK = 8'hFE;
  localparam int ID_OWN_LO = 4;
  localparam int ID_DEST_LO = 0;
  localparam logic [7:0] IDSEL_MASK = 8'h77;
  localparam int ST0_TARGET = 7;
  localparam int ST0_SEL_DONE = 6;
  localparam int ST0_SEL_IN = 5;
  localparam int ST0_SELECTING = 4;
  localparam int ST1_SEL_TIMEOUT = 7;
  localparam int ST1_CLRATN = 6;
  localparam int ST1_PERR = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [23:0] CNT_RST = 24'h000000;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int T_SELECTION_TIMEOUT_FLAG_MAX_MS = 256;
  localparam int SELECTION_TIMEOUT_FLAG_MAX_CYC = T_SELECTION_TIMEOUT_FLAG_MAX_MS * CLK_KHZ;
  localparam int TMR_W = 26;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } sss_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sss_axi_rsp_s;

  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic rst;
    logic io;
    logic cd;
    logic msg;
    logic req;
    logic [7:0] data;
    logic dp;
  } sss_bus_in_s;

  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic rst;
    logic io;
    logic [7:0] data;
  } sss_bus_out_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SELECTING, ST_ANSWER} sss_state_e;
endpackage : sss_pkg

// ### bench/sss_monitor.sv
module sss_monitor
  import sss_pkg::*;
#(
  parameter int unsigned P_SELECTION_TIMEOUT_FLAG_MAX_CYC = SELECTION_TIMEOUT_FLAG_MAX_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Watched ports
  input wire sss_axi_req_s i_axi,
  input wire sss_axi_rsp_s o_axi,
  input wire sss_bus_in_s i_bus,
  input wire sss_bus_out_s o_bus_out,
  input wire sss_bus_out_s o_bus_oe,
  input wire logic i_byte_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // Bus side
  boot_zero_a: assert property ($past(i_rst) |-> o_bus_out == '0)
    else $error("bus driven after reset");
  start_free_a: assert property ($rose(o_bus_out.sel) |-> $past(!i_bus.bsy && !i_bus.sel && !i_bus.rst, 2))
    else $error("selection began on a busy bus");
  id_bits_a: assert property ($rose(o_bus_out.sel) |-> o_bus_out.data != 8'h00 && $countones(o_bus_out.data) <= 2)
    else $error("bad id bits");
  sel_drop_a: assert property (o_bus_out.sel && i_bus.bsy |-> ##[1:3] !o_bus_out.sel)
    else $error("select held after busy");
  answer_bsy_a: assert property ($rose(o_bus_out.bsy) |-> $past(i_bus.sel, 2))
    else $error("busy without selection");
  atn_clear_a: assert property ($fell(o_bus_out.atn) |-> $past(!i_bus.bsy && !i_bus.sel, 2) || $past(o_axi.bvalid))
    else $error("attention dropped without cause");
  rst_write_a: assert property ($changed(o_bus_out.rst) |-> $past(o_axi.bvalid))
    else $error("reset out moved without a write");
  oe_same_a: assert property (o_bus_oe == o_bus_out)
    else $error("enable differs from value");
  rd_upper_a: assert property (o_axi.rvalid |-> o_axi.rdata[31:24] == 8'h00)
    else $error("upper read bits set");
  cover property ($rose(o_bus_out.sel));
  cover property ($rose(o_bus_out.bsy));
  cover property ($rose(o_bus_out.atn));
endmodule : sss_monitor

// ### bench/sss_scsi_peer.sv
module sss_scsi_peer
  import sss_pkg::*;
#(
  parameter int P_ID = 3
) (
  // Control
  input wire logic i_ref_clk,
  input wire logic [7:0] i_dly,
  input wire logic i_go,
  input wire logic i_io,
  input wire logic [7:0] i_tgt,
  input wire logic i_rst_on,
  // Bus
  input wire sss_bus_out_s i_dut,
  output sss_bus_in_s o_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Released lines read 0, since terminators pull every line deasserted.
  int cnt = 0;
  logic seen = 1'b0;
  logic s;
  logic [7:0] d;
  initial o_bus = '0;
  always @(posedge i_ref_clk) begin
    s = i_go && !seen && !i_dut.bsy;
    d = s ? (i_tgt | 8'(1 << P_ID)) : 8'h00;
    cnt <= (i_dut.sel && i_dut.data[P_ID]) ? cnt + 1 : 0;
    seen <= i_go && (seen || i_dut.bsy);
    o_bus.sel <= s;
    o_bus.io <= s && i_io;
    o_bus.data <= d;
    o_bus.dp <= ~^d;
    o_bus.rst <= i_rst_on;
    o_bus.bsy <= (i_dly != 0 && cnt >= i_dly && i_dut.sel) || (seen && i_io);
  end
endmodule : sss_scsi_peer

// ### bench/tb.sv
module tb
  import sss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned P_TMO = 64;
  logic clk;
  logic rst;
  logic bd;
  sss_axi_req_s ax;
  sss_axi_rsp_s ra;
  sss_bus_in_s bi;
  sss_bus_out_s bo;
  logic [7:0] p_dly;
  logic p_go;
  logic p_io;
  logic [7:0] p_tgt;
  logic p_rst;
  int err_total = 0;
  int cmp_count = 0;
  sss_top #(.P_SELECTION_TIMEOUT_FLAG_MAX_CYC(P_TMO)) dut (.i_ref_clk(clk), .i_rst(rst), .i_axi(ax), .o_axi(ra),
    .i_bus(bi), .o_bus_out(bo), .o_bus_oe(), .i_byte_done(bd));
  sss_scsi_peer peer (.i_ref_clk(clk), .i_dly(p_dly), .i_go(p_go), .i_io(p_io), .i_tgt(p_tgt),
    .i_rst_on(p_rst), .i_dut(bo), .o_bus(bi));
  // ==========
  // Bus tasks
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic ka;
    logic kw;
    ka = 1'b0;
    kw = 1'b0;
    ax.awaddr <= a;
    ax.wdata <= {24'h000000, d};
    ax.wstrb <= 4'hF;
    ax.awvalid <= 1'b1;
    ax.wvalid <= 1'b1;
    ax.bready <= 1'b1;
    do begin
      @(posedge clk);
      ka = ka | ra.awready;
      kw = kw | ra.wready;
      if (ka) ax.awvalid <= 1'b0;
      if (kw) ax.wvalid <= 1'b0;
    end while (ra.bvalid !== 1'b1);
    chk(ra.bresp === r, "write response");
    ax.bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    ax.araddr <= a;
    ax.arvalid <= 1'b1;
    ax.rready <= 1'b1;
    do @(posedge clk); while (ra.arready !== 1'b1);
    ax.arvalid <= 1'b0;
    do @(posedge clk); while (ra.rvalid !== 1'b1);
    chk(ra.rdata === e && ra.rresp === r, "read value");
    ax.rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // ==========
  // Scenarios
  task automatic t_reset();
    rd(ADDR_SEQ, 32'h0);
    rd(ADDR_XC0, 32'h0);
    rd(ADDR_XC1, 32'h0);
    rd(ADDR_ST0, 32'h0);
    rd(ADDR_ST1, 32'h0);
    rd(ADDR_CNT, 32'h0);
    rd(12'h004, 32'h0, RESP_SLVERR);
    wr(12'h004, 8'hFF, RESP_SLVERR);
    $display("reset test done");
  endtask : t_reset
  task automatic t_busrst();
    wr(ADDR_SEQ, 8'h0F);
    rd(ADDR_SEQ, 32'h0F);
    chk(bo.rst === 1'b1, "reset drive");
    p_rst <= 1'b1;
    cyc(3);
    p_rst <= 1'b0;
    rd(ADDR_SEQ, 32'h01);
    wr(ADDR_SEQ, 8'h00);
    chk(bo.rst === 1'b0, "reset release");
    $display("bus reset test done");
  endtask : t_busrst
  task automatic t_selo();
    wr(ADDR_IDSEL, 8'h73);
    p_dly <= 8'd40;
    wr(ADDR_SEQ, 8'h48);
    while (bo.sel !== 1'b1) @(posedge clk);
    chk(bo.data === 8'h88 && bo.io === 1'b0, "select ids");
    chk(bo.atn === 1'b1, "select attention");
    rd(ADDR_ST0, 32'h10);
    while (bo.sel !== 1'b0) @(posedge clk);
    rd(ADDR_ST0, 32'h40);
    rd(ADDR_SEQ, 32'h08);
    wr(ADDR_ST0, 8'h60);
    p_dly <= 8'h00;
    $display("selection test done");
  endtask : t_selo
  task automatic t_tmo();
    wr(ADDR_XC1, 8'h1C);
    wr(ADDR_IDSEL, 8'h75);
    wr(ADDR_SEQ, 8'h40);
    while (bo.sel !== 1'b1) @(posedge clk);
    // Code 11 gives an eighth of the full limit; a wrong code keeps select up.
    cyc((P_TMO >> 3) + 4);
    chk(bo.sel === 1'b0, "timeout drop");
    rd(ADDR_ST1, 32'h80);
    rd(ADDR_SEQ, 32'h00);
    wr(ADDR_ST1, 8'h80);
    wr(ADDR_XC1, 8'h00);
    $display("timeout test done");
  endtask : t_tmo
  task automatic t_seli();
    wr(ADDR_IDSEL, 8'h70);
    wr(ADDR_SEQ, 8'h20);
    p_tgt <= 8'h80;
    p_go <= 1'b1;
    while (bo.bsy !== 1'b1) @(posedge clk);
    rd(ADDR_ST0, 32'hA0);
    p_go <= 1'b0;
    wr(ADDR_ST0, 8'h60);
    wr(ADDR_SEQ, 8'h14);
    p_io <= 1'b1;
    p_go <= 1'b1;
    while (bo.bsy !== 1'b1) @(posedge clk);
    cyc(2);
    chk(bo.atn === 1'b1, "reselect attention");
    rd(ADDR_ST0, 32'h20);
    rd(ADDR_SEQ, 32'h14);
    wr(ADDR_ST1, 8'h40);
    chk(bo.atn === 1'b0, "attention clear");
    p_go <= 1'b0;
    p_io <= 1'b0;
    $display("selection in test done");
  endtask : t_seli
  task automatic t_cnt();
    repeat (3) begin
      bd <= 1'b1;
      cyc(1);
      bd <= 1'b0;
      cyc(1);
    end
    rd(ADDR_CNT, 32'h3);
    wr(ADDR_XC0, 8'h10);
    rd(ADDR_CNT, 32'h0);
    wr(ADDR_XC0, 8'h00);
    $display("counter test done");
  endtask : t_cnt
  // ==========
  // Run
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100us;
    err_total++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    ax = '0;
    bd = 1'b0;
    p_dly = 8'h00;
    p_go = 1'b0;
    p_io = 1'b0;
    p_tgt = 8'h00;
    p_rst = 1'b0;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_busrst();
    t_selo();
    t_tmo();
    t_seli();
    t_cnt();
    give_verdict();
  end
endmodule : tb
bind sss_top sss_monitor #(.P_SELECTION_TIMEOUT_FLAG_MAX_CYC(P_SELECTION_TIMEOUT_FLAG_MAX_CYC)) u_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_axi(i_axi), .o_axi(o_axi), .i_bus(i_bus), .o_bus_out(o_bus_out), .o_bus_oe(o_bus_oe),
  .i_byte_done(i_byte_done));
